//--- dv/otap_alarm_tb.sv
// Self-checking bench for the alarm line control block.
// Assumes otap_pkg and the partner model are compiled first.
`timescale 1ns/100ps
module otap_alarm_tb;
    import otap_pkg::*;
    logic        sys_clk, reset, psel, penable, pwrite, go, meas_valid;
    logic        pready, pslverr, line, oe, tach, alert;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] plen;
    logic [1:0]  meas_chan;
    logic [9:0]  meas_temp, e;
    logic [7:0]  fi0, fi1, fi2, fo0, fo1, fo2, d0, d2;
    logic [9:0]  expq[$];
    int          errors, n_tests, cyc;

    otap_alarm #(.TICK_CYC(20)) uut (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .overtemp_alarm_line_in(line),
        .overtemp_alarm_line_out(), .overtemp_alarm_line_oe(oe),
        .fourth_fan_tach_input(tach), .meas_valid(meas_valid),
        .meas_chan(meas_chan), .meas_temp(meas_temp),
        .fan_duty_in_0(fi0), .fan_duty_in_1(fi1), .fan_duty_in_2(fi2),
        .fan_duty_out_0(fo0), .fan_duty_out_1(fo1),
        .fan_duty_out_2(fo2), .alert_out(alert)
    );
    otap_hot_src hot_src (
        .sys_clk(sys_clk), .go(go), .len(plen), .dev_oe(oe), .line(line)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_sig
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    // Bit 9 of a note says whether the read data is compared
    task automatic rd(input logic [7:0] i, input logic [9:0] x);
        expq.push_back(x);
        apb(1'b0, i, 8'h00);
    endtask : rd
    task automatic meas(input logic [1:0] c, input logic [9:0] t);
        meas_chan <= c;
        meas_temp <= t;
        meas_valid <= 1'b1;
        repeat (4) @(posedge sys_clk);
        meas_valid <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : meas
    task automatic hot(input logic [15:0] n);
        go <= 1'b1;
        plen <= n;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask : hot
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    ////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expq.pop_front();
            chk_rd({pslverr, e[9] ? prdata[7:0] : e[7:0]}, e[8:0]);
        end
        cyc++;
        if (cyc == 30000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        {reset, psel, penable, pwrite, go, meas_valid} = 6'h20;
        {paddr, pwdata, plen, meas_chan, meas_temp} = '0;
        {fi0, fi1, fi2} = '0;
        void'($urandom(32'h9ff0294a));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
            rd(OTAP_IDX_R1_LIMIT + 8'(i), {2'b10, OTAP_RST_LIMIT});
        rd(OTAP_IDX_MASK_TWO, 10'h200);
        rd(OTAP_IDX_CFG_THREE, 10'h200);
        rd(OTAP_IDX_CFG_FIVE, 10'h200);
        rd(OTAP_IDX_CFG_FOUR, 10'h200);
        rd(OTAP_IDX_TIMER, 10'h200);
        rd(8'h00, 10'h100);
        end_test("registers");
        wr(OTAP_IDX_CFG_FOUR, {6'h00, OTAP_FUNC_ALARM});
        wr(OTAP_IDX_CFG_THREE, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wr(OTAP_IDX_R1_LIMIT + 8'(i), 8'h50);
            rd(OTAP_IDX_R1_LIMIT + 8'(i), 10'h250);
            wr(OTAP_IDX_CFG_FIVE, 8'h00);
            meas(2'(i), 10'h141);
            chk_sig({7'h00, oe}, 8'h00);
            meas(2'(i), 10'h140);
            wr(OTAP_IDX_CFG_FIVE, 8'(8'h20 << i));
            meas(2'((i + 1) % 3), 10'h1ff);
            chk_sig({7'h00, oe}, 8'h00);
            meas(2'(i), 10'h140);
            chk_sig({7'h00, oe}, 8'h00);
            meas(2'(i), 10'h141);
            chk_sig({7'h00, oe}, 8'h01);
            repeat (40) @(posedge sys_clk);
            chk_sig({7'h00, oe}, 8'h01);
            meas(2'(i), 10'h150);
            chk_sig({7'h00, oe}, 8'h01);
            meas(2'(i), 10'h140);
            chk_sig({7'h00, oe}, 8'h00);
        end
        wr(OTAP_IDX_CFG_FIVE, 8'h20);
        wr(OTAP_IDX_R1_LIMIT, OTAP_DIS_TWOS);
        meas(2'd0, 10'h3ff);
        chk_sig({7'h00, oe}, 8'h00);
        wr(OTAP_IDX_CFG_FIVE, 8'h21);
        wr(OTAP_IDX_R1_LIMIT, OTAP_DIS_OFF64);
        meas(2'd0, 10'h100);
        chk_sig({7'h00, oe}, 8'h00);
        wr(OTAP_IDX_CFG_FIVE, 8'h20);
        wr(OTAP_IDX_R1_LIMIT, 8'h50);
        meas(2'd0, 10'h141);
        wr(OTAP_IDX_CFG_THREE, 8'h00);
        repeat (8) @(posedge sys_clk);
        chk_sig({7'h00, oe}, 8'h00);
        end_test("output");
        // Mid-run reset clears the tick counter left by the output test
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        wr(OTAP_IDX_CFG_FOUR, {6'h00, OTAP_FUNC_ALARM});
        wr(OTAP_IDX_CFG_FIVE, 8'h00);
        wr(OTAP_IDX_CFG_THREE, 8'h02);
        wr(OTAP_IDX_TIME_LIMIT, 8'h00);
        rd(OTAP_IDX_TIMER, 10'h000);
        rd(OTAP_IDX_STATUS_TWO, 10'h000);
        hot(16'd8);
        repeat (20) @(posedge sys_clk);
        chk_sig({7'h00, alert}, 8'h01);
        rd(OTAP_IDX_TIMER, 10'h201);
        rd(OTAP_IDX_TIMER, 10'h200);
        rd(OTAP_IDX_STATUS_TWO, 10'h220);
        @(posedge sys_clk);
        chk_sig({7'h00, alert}, 8'h00);
        wr(OTAP_IDX_MASK_TWO, 8'h20);
        hot(16'd8);
        repeat (20) @(posedge sys_clk);
        chk_sig({7'h00, alert}, 8'h00);
        rd(OTAP_IDX_TIMER, 10'h000);
        rd(OTAP_IDX_STATUS_TWO, 10'h220);
        hot(16'd6000);
        repeat (6010) @(posedge sys_clk);
        rd(OTAP_IDX_TIMER, 10'h2ff);
        wr(OTAP_IDX_CFG_THREE, 8'h00);
        hot(16'd8);
        repeat (20) @(posedge sys_clk);
        rd(OTAP_IDX_TIMER, 10'h200);
        wr(OTAP_IDX_CFG_THREE, 8'h02);
        for (int c = 0; c < 4; c++) begin
            if (c == 1)
                continue;
            wr(OTAP_IDX_CFG_FOUR, 8'(c));
            hot(16'd30);
            repeat (10) @(posedge sys_clk);
            chk_sig({7'h00, tach}, (c == 0) ? 8'h00 : 8'h01);
            repeat (30) @(posedge sys_clk);
            rd(OTAP_IDX_TIMER, 10'h200);
        end
        end_test("timer");
        wr(OTAP_IDX_CFG_FOUR, {6'h00, OTAP_FUNC_ALARM});
        wr(OTAP_IDX_CFG_THREE, 8'h06);
        d0 = 8'h01 + 8'($urandom % 254);
        d2 = 8'h01 + 8'($urandom % 254);
        fi0 <= d0;
        fi1 <= 8'h00;
        fi2 <= d2;
        hot(16'd100);
        repeat (10) @(posedge sys_clk);
        chk_sig(fo0, OTAP_DUTY_FULL);
        chk_sig(fo1, 8'h00);
        chk_sig(fo2, OTAP_DUTY_FULL);
        repeat (100) @(posedge sys_clk);
        chk_sig(fo0, d0);
        wr(OTAP_IDX_CFG_THREE, 8'h02);
        hot(16'd50);
        repeat (10) @(posedge sys_clk);
        chk_sig(fo2, d2);
        repeat (50) @(posedge sys_clk);
        end_test("full_fan_on_alarm");
        final_report();
    end
endmodule : otap_alarm_tb

//--- dv/otap_hot_src.sv
// Model of an external hot signal sharing the alarm line.
// Assumes a pull-up on the line and open-drain drivers only.
`timescale 1ns/100ps
module otap_hot_src (
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic [15:0] len,
    input  wire logic        dev_oe,
    output logic             line
);
    logic [15:0] left_r;
    initial left_r = 16'h0000;
    // Holds the line low for len cycles after each go
    always @(posedge sys_clk) begin
        if (go)
            left_r <= len;
        else if (left_r != 16'h0000)
            left_r <= left_r - 16'h0001;
    end
    // Wired-AND with pull-up: a released line reads high
    assign line = !((left_r != 16'h0000) || dev_oe);
endmodule : otap_hot_src

//--- hw/otap_alarm.sv
// Overtemperature alarm line control: timer, output drive, fan full_fan_on_alarm.
// Assumes an APB master on sys_clk and async line and temperature inputs.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Timer monitors only while monitor-enable set
// - Alarm function needs select code and enable
// - Three enable bits: remote1, local, remote2
// - External low assertions are timed too
// - No enables: never drive, input only
// - Full_fan_on_alarm runs fans full while asserted
// - Stopped fans stay stopped under full_fan_on_alarm
// - Mask blocks alert, not status flag
// - Limit zero alerts on first assertion
// - Drive low when temperature exceeds limit
// - Stay low until reading at or below
// - Output assertion lasts a monitoring cycle
// - Three writable limits at consecutive addresses
// - Very low limit disables channel output
// - Enable clear stops timing and driving
// - Select code 01 picks alarm function
// - Timer accumulates, clears on read, saturates
// - First assertion sets LSB, then counts
// - Over limit sets flag and alert
module otap_alarm #(
    parameter int TICK_CYC = otap_pkg::OTAP_TICK_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        overtemp_alarm_line_in,
    output logic             overtemp_alarm_line_out,
    output logic             overtemp_alarm_line_oe,
    output logic             fourth_fan_tach_input,
    input  wire logic        meas_valid,
    input  wire logic [1:0]  meas_chan,
    input  wire logic [9:0]  meas_temp,
    input  wire logic [7:0]  fan_duty_in_0,
    input  wire logic [7:0]  fan_duty_in_1,
    input  wire logic [7:0]  fan_duty_in_2,
    output logic [7:0]       fan_duty_out_0,
    output logic [7:0]       fan_duty_out_1,
    output logic [7:0]       fan_duty_out_2,
    output logic             alert_out
);
    import otap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] boosted(input logic [7:0] d,
                                           input logic       b);
        boosted = (b && d != 8'h00) ? OTAP_DUTY_FULL : d;
    endfunction : boosted

    function automatic logic lim_off(input logic [7:0] l,
                                     input logic       off64);
        lim_off = off64 ? (l <= OTAP_DIS_OFF64)
                        : (l == OTAP_DIS_TWOS);
    endfunction : lim_off

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] lim_r [3];
    logic [7:0] mask_two_r, cfg3_r, cfg4_r, cfg5_r, tlimit_r;
    logic [7:0] timer_r, status2_r;
    logic       line_s1_r, line_s2_r, prev_asrt_r;
    logic       tmp_v_s1_r, tmp_v_s2_r, tmp_v_d_r;
    logic [2:0] trip_r;
    logic [7:0] dout0_r, dout1_r, dout2_r;
    logic       fourth_r, alert_r;
    logic       drive_low;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire        setup   = psel && !penable;
    wire        access  = psel && penable;
    wire [9:0]  word    = paddr[11:2];
    wire        wr      = access && pwrite;
    wire        rd      = access && !pwrite;
    wire        hit_l0  = word == {2'b00, OTAP_IDX_R1_LIMIT};
    wire        hit_l1  = word == {2'b00, OTAP_IDX_LOC_LIMIT};
    wire        hit_l2  = word == {2'b00, OTAP_IDX_R2_LIMIT};
    wire        hit_mk  = word == {2'b00, OTAP_IDX_MASK_TWO};
    wire        hit_c3  = word == {2'b00, OTAP_IDX_CFG_THREE};
    wire        hit_tm  = word == {2'b00, OTAP_IDX_TIMER};
    wire        hit_tl  = word == {2'b00, OTAP_IDX_TIME_LIMIT};
    wire        hit_c5  = word == {2'b00, OTAP_IDX_CFG_FIVE};
    wire        hit_c4  = word == {2'b00, OTAP_IDX_CFG_FOUR};
    wire        hit_st  = word == {2'b00, OTAP_IDX_STATUS_TWO};
    wire        mapped  = hit_l0 | hit_l1 | hit_l2 | hit_mk | hit_c3
                        | hit_tm | hit_tl | hit_c5 | hit_c4 | hit_st;
    wire [7:0]  rsel    = hit_l0 ? lim_r[0] : hit_l1 ? lim_r[1]
                        : hit_l2 ? lim_r[2] : hit_mk ? mask_two_r
                        : hit_c3 ? cfg3_r   : hit_tm ? timer_r
                        : hit_tl ? tlimit_r : hit_c5 ? cfg5_r
                        : hit_c4 ? cfg4_r   : hit_st ? status2_r : 8'h00;

    wire       mon_en   = cfg3_r[OTAP_MON_EN_BIT];
    wire [1:0] func_sel = cfg4_r[OTAP_FUNC_LSB +: 2];
    wire       active   = mon_en && func_sel == OTAP_FUNC_ALARM;
    wire [2:0] out_en   = cfg5_r[OTAP_OUT_EN_LSB +: 3];
    wire       full_fan_on_alarm_en = cfg3_r[OTAP_FULL_FAN_ON_ALARM_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and assertion detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            line_s1_r  <= 1'b1;
            line_s2_r  <= 1'b1;
            tmp_v_s1_r <= 1'b0;
            tmp_v_s2_r <= 1'b0;
            tmp_v_d_r  <= 1'b0;
        end else if (clk_en) begin
            line_s1_r  <= overtemp_alarm_line_in;
            line_s2_r  <= line_s1_r;
            tmp_v_s1_r <= meas_valid;
            tmp_v_s2_r <= tmp_v_s1_r;
            tmp_v_d_r  <= tmp_v_s2_r;
        end
    end
    // Wired-AND line level: own drive or external pull both count
    wire asserted  = active && (!line_s2_r || drive_low);
    wire new_asrt  = asserted && !prev_asrt_r;
    wire meas_stb  = tmp_v_s2_r && !tmp_v_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Timebase
    otap_tick_if tk ();
    assign tk.run = asserted;
    otap_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .tk      (tk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertion timer and flag
    // Clear-on-read only at the completing edge
    wire rd_done  = rd && pready;
    wire rd_timer = rd_done && hit_tm;
    wire rd_stat  = rd_done && hit_st;
    wire sat      = timer_r == OTAP_FULL;
    logic [7:0] timer_nxt;
    always_comb begin
        timer_nxt = rd_timer ? 8'h00 : timer_r;
        if (rd_timer && asserted) begin
            timer_nxt = 8'h01;
        end else if (new_asrt && timer_r == 8'h00) begin
            timer_nxt = 8'h01;
        end else if (tk.tick && !sat && !rd_timer) begin
            timer_nxt = (timer_r == 8'h01) ? 8'h02 : timer_r + 8'h01;
        end
    end
    // Limit zero fires once any assertion has been seen
    wire over = (timer_nxt > tlimit_r) ||
                (tlimit_r == 8'h00 && timer_nxt != 8'h00);
    wire flag_set = active && over;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_r     <= OTAP_RST_ZERO;
            prev_asrt_r <= 1'b0;
            status2_r   <= OTAP_RST_ZERO;
        end else if (clk_en) begin
            timer_r     <= mon_en ? timer_nxt : timer_r;
            prev_asrt_r <= asserted;
            // Set wins over clear-on-read
            status2_r[OTAP_FLAG_BIT] <= flag_set ||
                (status2_r[OTAP_FLAG_BIT] && !rd_stat);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive per channel
    logic [2:0] trip_nxt;
    always_comb begin
        trip_nxt = trip_r;
        if (meas_stb) begin
            // Greater than limit means at least a quarter degree above
            trip_nxt[meas_chan[1:0] == 2'd3 ? 2'd0 : meas_chan] =
                meas_temp > {lim_r[meas_chan == 2'd3 ? 2'd0 : meas_chan],
                             2'b00};
        end
        if (!active) begin
            trip_nxt = 3'b000;
        end
    end
    wire [2:0] ch_off = {lim_off(lim_r[2], cfg5_r[OTAP_OFFSET64_BIT]),
                         lim_off(lim_r[1], cfg5_r[OTAP_OFFSET64_BIT]),
                         lim_off(lim_r[0], cfg5_r[OTAP_OFFSET64_BIT])};
    // Trip changes only on a new reading or when inactive, so it holds a whole cycle
    assign drive_low = |(trip_r & out_en & ~ch_off);

    ////////////////////////////////////////////////////////////////////////
    // Register writes and APB answer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lim_r[0]   <= OTAP_RST_LIMIT;
            lim_r[1]   <= OTAP_RST_LIMIT;
            lim_r[2]   <= OTAP_RST_LIMIT;
            mask_two_r <= OTAP_RST_ZERO;
            cfg3_r     <= OTAP_RST_ZERO;
            cfg4_r     <= OTAP_RST_ZERO;
            cfg5_r     <= OTAP_RST_ZERO;
            tlimit_r   <= OTAP_RST_TLIMIT;
            pready     <= 1'b0;
            prdata     <= 32'h0;
            pslverr    <= 1'b0;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? {24'h0, rsel} : 32'h0;
            if (wr && pready) begin
                if (hit_l0) lim_r[0]   <= pwdata[7:0];
                if (hit_l1) lim_r[1]   <= pwdata[7:0];
                if (hit_l2) lim_r[2]   <= pwdata[7:0];
                if (hit_mk) mask_two_r <= pwdata[7:0];
                if (hit_c3) cfg3_r     <= pwdata[7:0];
                if (hit_c4) cfg4_r     <= pwdata[7:0];
                if (hit_c5) cfg5_r     <= pwdata[7:0];
                if (hit_tl) tlimit_r   <= pwdata[7:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trip_r  <= 3'b000;
            dout0_r <= 8'h00;
            dout1_r <= 8'h00;
            dout2_r <= 8'h00;
            fourth_r <= 1'b1;
            alert_r <= 1'b0;
            overtemp_alarm_line_out <= 1'b0;
            overtemp_alarm_line_oe  <= 1'b0;
        end else if (clk_en) begin
            trip_r  <= trip_nxt;
            dout0_r <= boosted(fan_duty_in_0, full_fan_on_alarm_en && asserted);
            dout1_r <= boosted(fan_duty_in_1, full_fan_on_alarm_en && asserted);
            dout2_r <= boosted(fan_duty_in_2, full_fan_on_alarm_en && asserted);
            fourth_r <= (func_sel == OTAP_FUNC_TACH) ? line_s2_r : 1'b1;
            alert_r <= status2_r[OTAP_FLAG_BIT] &&
                       !mask_two_r[OTAP_FLAG_BIT];
            overtemp_alarm_line_out <= 1'b0;
            overtemp_alarm_line_oe  <= active &&
                                       |(trip_nxt & out_en & ~ch_off);
        end
    end
    assign fan_duty_out_0        = dout0_r;
    assign fan_duty_out_1        = dout1_r;
    assign fan_duty_out_2        = dout2_r;
    assign fourth_fan_tach_input = fourth_r;
    assign alert_out             = alert_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_oe_needs_enable: assert property (@(posedge sys_clk) disable iff (reset)
        (out_en == 3'b000 || !mon_en) |=> !overtemp_alarm_line_oe)
        else $error("alarm line driven while not enabled");
    a_mask_alert: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && mask_two_r[OTAP_FLAG_BIT] |=> !alert_out)
        else $error("masked alert raised");
    a_flag_kept: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && flag_set |=> status2_r[OTAP_FLAG_BIT])
        else $error("time exceeded flag missed");
    a_timer_sat: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && sat && !rd_timer |=> timer_r == OTAP_FULL)
        else $error("timer left full scale without read");
    a_first_lsb: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && mon_en && new_asrt && timer_r == 8'h00 && !rd_timer
        |=> timer_r == 8'h01)
        else $error("first assertion did not set lsb");
    a_full_fan_on_alarm_full: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && full_fan_on_alarm_en && asserted && fan_duty_in_1 != 8'h00
        |=> fan_duty_out_1 == OTAP_DUTY_FULL)
        else $error("full_fan_on_alarm did not reach full duty");
    a_stopped_fan: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && fan_duty_in_0 == 8'h00 |=> fan_duty_out_0 == 8'h00)
        else $error("stopped fan started by full_fan_on_alarm");
    a_no_mon_timer: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !mon_en |=> $stable(timer_r))
        else $error("timer moved while monitoring disabled");
    a_apb_ready: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && setup |=> pready)
        else $error("apb answer not one cycle after setup");
    c_ext_assert: cover property (@(posedge sys_clk) new_asrt && !drive_low);
    c_own_drive: cover property (@(posedge sys_clk) overtemp_alarm_line_oe);
    c_flag: cover property (@(posedge sys_clk) flag_set);
    c_full_fan_on_alarm: cover property (@(posedge sys_clk) full_fan_on_alarm_en && asserted);
endmodule : otap_alarm

//--- hw/otap_pkg.sv
// Package for the overtemperature alarm pin control block.
// Assumes one 250 MHz clock and an APB register port.
package otap_pkg;
    // Register word indices, byte address is four times the index (printed offsets are not all multiples of four)
    localparam logic [7:0] OTAP_IDX_R1_LIMIT   = 8'h6a;
    localparam logic [7:0] OTAP_IDX_LOC_LIMIT  = 8'h6b;
    localparam logic [7:0] OTAP_IDX_R2_LIMIT   = 8'h6c;
    localparam logic [7:0] OTAP_IDX_MASK_TWO   = 8'h75;
    localparam logic [7:0] OTAP_IDX_CFG_THREE  = 8'h78;
    localparam logic [7:0] OTAP_IDX_TIMER      = 8'h79;
    localparam logic [7:0] OTAP_IDX_TIME_LIMIT = 8'h7a;
    localparam logic [7:0] OTAP_IDX_CFG_FIVE   = 8'h7c;
    localparam logic [7:0] OTAP_IDX_CFG_FOUR   = 8'h7d;
    localparam logic [7:0] OTAP_IDX_STATUS_TWO = 8'h80;
    localparam logic [7:0] OTAP_IDX_TEMP_IN    = 8'h81;
    // Field positions
    localparam int OTAP_MON_EN_BIT   = 1;
    localparam int OTAP_FULL_FAN_ON_ALARM_BIT    = 2;
    localparam int OTAP_FLAG_BIT     = 5;
    localparam int OTAP_OUT_EN_LSB   = 5;
    localparam int OTAP_FUNC_LSB     = 0;
    localparam int OTAP_OFFSET64_BIT = 0;
    localparam logic [1:0] OTAP_FUNC_TACH  = 2'h0;
    localparam logic [1:0] OTAP_FUNC_ALARM = 2'h1;
    localparam logic [1:0] OTAP_FUNC_ALERT = 2'h2;
    localparam logic [1:0] OTAP_FUNC_GPIO  = 2'h3;
    // Reset values
    localparam logic [7:0] OTAP_RST_LIMIT  = 8'h64;
    localparam logic [7:0] OTAP_RST_ZERO   = 8'h00;
    localparam logic [7:0] OTAP_RST_TLIMIT = 8'h00;
    // Disabled-limit thresholds: offset-64 code for -64 C, 2s comp for -128 C
    localparam logic [7:0] OTAP_DIS_OFF64 = 8'h00;
    localparam logic [7:0] OTAP_DIS_TWOS  = 8'h80;
    // Timer base resolution in microseconds and in clock cycles
    localparam real OTAP_CLK_MHZ   = 250.0;
    localparam real OTAP_TICK_US   = 22760.0;
    localparam int  OTAP_TICK_CYC  = int'(OTAP_TICK_US * OTAP_CLK_MHZ);
    localparam logic [7:0] OTAP_FULL = 8'hff;
    localparam logic [7:0] OTAP_DUTY_FULL = 8'hff;
endpackage : otap_pkg

//--- hw/otap_tick_gen.sv
// Timebase for the assertion timer: one tick per base resolution.
// Assumes sys_clk at 250 MHz; runs only while run is high.
`timescale 1ns/100ps
module otap_tick_gen #(
    parameter int TICK_CYC = otap_pkg::OTAP_TICK_CYC
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    otap_tick_if.src  tk
);
    import otap_pkg::*;
    logic [31:0] cnt_r;
    wire         wrap = (cnt_r == 32'(TICK_CYC - 1));
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_r   <= 32'h0;
            tk.tick <= 1'b0;
        end else if (clk_en) begin
            tk.tick <= tk.run && wrap;
            if (tk.run) begin
                cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
            end
        end
    end
endmodule : otap_tick_gen

//--- hw/otap_tick_if.sv
// Interface carrying the timebase tick between alarm modules.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
interface otap_tick_if;
    logic run;
    logic tick;
    modport src (input run, output tick);
    modport dst (output run, input tick);
endinterface : otap_tick_if
